// ### verilog/trap_drive.sv
// Sensorless trapezoidal drive core with AXI4-Lite register file
// Notes on behaviour
// [R01] Commutation is timed from the zero crossing on the floating phase.
// [R02] Selector 00: each phase driven 120, floating 60, six states.
// [R03] Modulation 00: high side switches, low side fully on.
// [R04] Modulation 01: low side switches, high side fully on.
// [R05] Modulation 10: high and low side switching alternate by state.
// [R06] Selector 01: drive extended with tapered duty; float 30 to 60.
// [R07] Variable commutation always uses mixed modulation.
// [R08] Lead is code times 0.12 degrees; sign 1 advances, 0 delays.
// [R09] In 120 mode negative lead below -20 is clamped to -20.
// [R10] In variable mode lead is clamped to 0..+15 degrees.
// [R11] Speed command slews at most by the acceleration rate; falls step by the decel rate (accel rate with surge guard).
// [R12] Loop mode 01: PI speed controller output sets duty.
// [R13] PI output bounded; integrator frozen while saturated.
// [R14] Speed reference is duty command times max speed, floored.
// [R15] Loop mode 10 regulates power; 01 closed, 10 limit.
// [R16] Power reference is duty command times max power, floored.
// [R17] Closed power control always applies PI output.
// [R18] Power limit uses PI only above reference plus hysteresis.
// [R19] Power PI shares speed gains, limits and anti-windup.
// [R20] Surge guard bit; when off, decel follows decel rate.
// [R21] PWM frequency selectable over 5 to 100 kHz.
// [R22] Six states step cyclically by direction, one per commutation.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module trap_drive #(
    parameter int unsigned CTRL_TICK = trap_drive_pkg::CTRL_TICK_CYC,
    parameter int unsigned ZC_TIMEOUT = trap_drive_pkg::ZC_TIMEOUT_CYC,
    parameter int unsigned VAR_FAST = trap_drive_pkg::VAR_FAST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] bemf_cmp,
    input wire logic [15:0] measured_power,
    output logic [2:0] hs_gate,
    output logic [2:0] ls_gate
);
    import trap_drive_pkg::*;
    // Phase lookups for a commutation state
    function automatic logic [1:0] hi_ph(input logic [2:0] s);
        hi_ph = (s < 3'h2) ? 2'h0 : (s < 3'h4) ? 2'h1 : 2'h2;
    endfunction
    function automatic logic [1:0] lo_ph(input logic [2:0] s);
        case (s)
            3'h0, 3'h5: lo_ph = 2'h1;
            3'h1, 3'h2: lo_ph = 2'h2;
            default: lo_ph = 2'h0;
        endcase
    endfunction
    function automatic logic [1:0] fl_ph(input logic [2:0] s);
        fl_ph = 2'h3 - hi_ph(s) - lo_ph(s);
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = st[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    logic [31:0] cfg_reg [NCFG];
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    // AXI4-Lite slave: write taken when address and data both present
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    wire wr_hit = s_axi_awaddr < ADDR_STATUS;
    wire rd_go = s_axi_arvalid && !rvalid_reg;
    wire [2:0] wr_idx = s_axi_awaddr[4:2];
    wire [2:0] rd_idx = s_axi_araddr[4:2];
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Configuration fields
    wire [1:0] commutation_select = cfg_reg[0][COMM_LSB +: 2];
    wire [1:0] modulation_select = cfg_reg[0][MOD_LSB +: 2];
    wire [1:0] loop_mode = cfg_reg[0][LOOP_LSB +: 2];
    wire [1:0] power_mode = cfg_reg[0][PMODE_LSB +: 2];
    wire surge_guard_enable = cfg_reg[0][SURGE_BIT];
    wire drive_enable = cfg_reg[0][EN_BIT];
    wire reverse_dir = cfg_reg[0][REV_BIT];
    wire [9:0] duty_cmd = cfg_reg[1][LO_LSB +: 10];
    wire [9:0] min_duty = cfg_reg[1][HI_LSB +: 10];
    wire [7:0] lead_angle_code = cfg_reg[2][LO_LSB +: 8];
    wire lead_angle_sign = cfg_reg[2][SIGN_BIT];
    wire [9:0] accel_rate_limit = cfg_reg[3][LO_LSB +: 10];
    wire [9:0] decel_rate_limit = cfg_reg[3][HI_LSB +: 10];
    wire [15:0] pi_proportional_gain = cfg_reg[4][LO_LSB +: 16];
    wire [15:0] pi_integral_gain = cfg_reg[4][HI_LSB +: 16];
    wire [9:0] pi_upper_limit = cfg_reg[5][LO_LSB +: 10];
    wire [9:0] pi_lower_limit = cfg_reg[5][HI_LSB +: 10];
    wire [15:0] max_speed = cfg_reg[6][LO_LSB +: 16];
    wire [15:0] max_power = cfg_reg[6][HI_LSB +: 16];
    wire [15:0] power_hysteresis = cfg_reg[7][LO_LSB +: 16];
    wire [6:0] switching_frequency_select = cfg_reg[7][HI_LSB +: 7];

    // Drive state
    logic [2:0] bemf_s1_reg, bemf_s2_reg, bemf_s3_reg;
    logic [2:0] cmp_lvl_reg, cmp_old_reg;
    logic [2:0] state_reg;
    zc_state_t zc_reg;
    logic [19:0] cnt_reg, period_reg, delay_reg, ext_reg;
    logic [13:0] pwm_cnt_reg;
    logic [2:0] hs_reg, ls_reg;
    logic [9:0] ramp_reg, duty_reg, pi_out_reg;
    logic [16:0] tick_reg;
    logic signed [35:0] integ_reg;
    assign hs_gate = hs_reg;
    assign ls_gate = ls_reg;

    // Status words
    wire [15:0] speed_meas;
    wire [31:0] status_word = {6'h00, duty_reg, 11'h000, zc_reg, 1'b0,
        state_reg};
    wire [31:0] meas_word = {6'h00, pi_out_reg, speed_meas};
    wire [31:0] rd_word = (s_axi_araddr < ADDR_STATUS) ? cfg_reg[rd_idx] :
        (s_axi_araddr[7:2] == ADDR_STATUS[7:2]) ? status_word : meas_word;
    wire rd_hit = s_axi_araddr[7:2] <= ADDR_MEAS[7:2];

    // Register file and bus answers; unmapped gives DECERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCFG; i++) begin
                cfg_reg[i] <= RST_CFG;
            end
            cfg_reg[5] <= RST_LIMITS;
            cfg_reg[7] <= RST_FREQ;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_go && wr_hit) begin
                cfg_reg[wr_idx] <= merge(cfg_reg[wr_idx], s_axi_wdata,
                    s_axi_wstrb);
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? 2'h0 : 2'h3;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_hit ? 2'h0 : 2'h3;
                rdata_reg <= rd_hit ? rd_word : 32'h0000_0000;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Lead angle in 0.04 degree units with mode clamps
    wire signed [11:0] lead_mag = 12'(lead_angle_code) * 12'(LEAD_SCALE);
    wire signed [11:0] lead_raw = lead_angle_sign ? lead_mag : -lead_mag;
    wire var_mode = commutation_select == COMM_VAR;
    wire signed [11:0] lead_eff = var_mode ?
        ((lead_raw < 0) ? 12'sh000 :
         (lead_raw > 12'(LEAD_MAX_VAR)) ? 12'(LEAD_MAX_VAR) : lead_raw) :
        ((lead_raw < 12'(LEAD_MIN_120)) ? 12'(LEAD_MIN_120) : lead_raw);
    // Advance shortens the wait from crossing to the 30 degree point
    wire signed [11:0] wait_ang = 12'(ANG_30) - lead_eff; // [R08]
    wire [10:0] wait_pos = (wait_ang < 0) ? 11'h000 : wait_ang[10:0];
    wire [31:0] delay_full = (32'(period_reg) * 32'(wait_pos)) /
        32'(ANG_60);

    // Zero crossing on the floating phase in the expected direction
    wire [1:0] fl = fl_ph(state_reg);
    wire expect_lvl = state_reg[0] ^ reverse_dir;
    wire zc_edge = (cmp_lvl_reg[fl] != cmp_old_reg[fl]) &&
        (cmp_lvl_reg[fl] == expect_lvl);
    wire zc_event = drive_enable && zc_reg == ST_WAIT && ext_reg == 20'h0
        && (zc_edge || 32'(cnt_reg) >= 32'(ZC_TIMEOUT) || &cnt_reg); // [R01]
    wire commutate = zc_reg == ST_DELAY && cnt_reg >= delay_reg;
    wire [2:0] state_next = reverse_dir ?
        ((state_reg == 3'h0) ? 3'h5 : state_reg - 3'h1) :
        ((state_reg == 3'h5) ? 3'h0 : state_reg + 3'h1);
    wire fast = period_reg < 20'(VAR_FAST);

    // Comparator synchroniser, crossing timer and state sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bemf_s1_reg <= 3'h0;
            bemf_s2_reg <= 3'h0;
            bemf_s3_reg <= 3'h0;
            cmp_lvl_reg <= 3'h0;
            cmp_old_reg <= 3'h0;
            state_reg <= 3'h0;
            zc_reg <= ST_WAIT;
            cnt_reg <= 20'h0;
            period_reg <= 20'hFFFFF;
            delay_reg <= 20'h0;
            ext_reg <= 20'h0;
        end else begin
            bemf_s1_reg <= bemf_cmp;
            bemf_s2_reg <= bemf_s1_reg;
            bemf_s3_reg <= bemf_s2_reg;
            for (int i = 0; i < 3; i++) begin
                if (bemf_s2_reg[i] == bemf_s3_reg[i]) begin
                    cmp_lvl_reg[i] <= bemf_s3_reg[i];
                end
            end
            cmp_old_reg <= cmp_lvl_reg;
            cnt_reg <= (cnt_reg == 20'hFFFFF) ? cnt_reg : cnt_reg + 20'h1;
            if (ext_reg != 20'h0) begin
                ext_reg <= ext_reg - 20'h1;
            end
            if (zc_event) begin
                period_reg <= (cnt_reg == 20'h0) ? 20'h1 : cnt_reg;
                cnt_reg <= 20'h0;
                zc_reg <= ST_DELAY;
            end else if (commutate) begin
                state_reg <= state_next; // [R22] [R02]
                zc_reg <= ST_WAIT;
                // Faster motor gets the shorter float window
                ext_reg <= (var_mode && fast) ? period_reg >> 1 : 20'h0;
            end
            delay_reg <= delay_full[19:0];
        end
    end

    // PWM period from selected frequency, clamped to range
    wire [6:0] f_khz = (switching_frequency_select < 7'(FREQ_MIN_KHZ)) ?
        7'(FREQ_MIN_KHZ) : (switching_frequency_select > 7'(FREQ_MAX_KHZ))
        ? 7'(FREQ_MAX_KHZ) : switching_frequency_select;
    wire [31:0] pwm_per32 = 32'(CLK_KHZ) / 32'(f_khz); // [R21]
    wire [13:0] pwm_per = pwm_per32[13:0];
    wire [23:0] pwm_pos = {pwm_cnt_reg, 10'h000};
    wire pwm_on = pwm_pos < 24'(duty_reg) * 24'(pwm_per);
    wire pwm_taper = pwm_pos < 24'(duty_reg >> 1) * 24'(pwm_per); // [R06]

    // Effective modulation and gate pattern
    wire [1:0] eff_mod = var_mode ? MOD_MIX : modulation_select; // [R07]
    wire hs_switch = eff_mod == MOD_HS ||
        (eff_mod == MOD_MIX && !state_reg[0]); // [R03] [R04] [R05]
    wire [2:0] prev_s = reverse_dir ?
        ((state_reg == 3'h5) ? 3'h0 : state_reg + 3'h1) :
        ((state_reg == 3'h0) ? 3'h5 : state_reg - 3'h1);
    wire out_was_hi = hi_ph(prev_s) == fl;
    wire run = drive_enable && commutation_select <= COMM_VAR;
    wire in_ext = ext_reg != 20'h0;
    logic [2:0] hs_next, ls_next;
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            wire is_hi = hi_ph(state_reg) == 2'(p);
            wire is_lo = lo_ph(state_reg) == 2'(p);
            wire is_ext = in_ext && fl == 2'(p);
            assign hs_next[p] = run && ((is_hi && (hs_switch ? pwm_on :
                1'b1)) || (is_ext && out_was_hi && pwm_taper));
            assign ls_next[p] = run && ((is_lo && (hs_switch ? 1'b1 :
                pwm_on)) || (is_ext && !out_was_hi && pwm_taper));
        end
    endgenerate

    // PWM counter and registered gates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_cnt_reg <= 14'h0;
            hs_reg <= 3'h0;
            ls_reg <= 3'h0;
        end else begin
            pwm_cnt_reg <= (pwm_cnt_reg >= pwm_per - 14'h1) ? 14'h0 :
                pwm_cnt_reg + 14'h1;
            hs_reg <= hs_next;
            ls_reg <= ls_next;
        end
    end

    // Speed in electrical Hz and references with floors
    wire [31:0] spd32 = 32'(CLK_HZ) / (32'(period_reg) * 32'h6);
    assign speed_meas = (spd32 > 32'h0000FFFF) ? 16'hFFFF : spd32[15:0];
    wire [25:0] sref_a = 26'(max_speed) * 26'(ramp_reg);
    wire [25:0] sref_b = 26'(max_speed) * 26'(min_duty);
    wire [15:0] speed_ref = (sref_a > sref_b) ? sref_a[25:10] :
        sref_b[25:10]; // [R14]
    wire [25:0] pref_a = 26'(max_power) * 26'(ramp_reg);
    wire [25:0] pref_b = 26'(max_power) * 26'(min_duty);
    wire [15:0] power_ref = (pref_a > pref_b) ? pref_a[25:10] :
        pref_b[25:10]; // [R16]
    wire power_loop = loop_mode == LOOP_POWER; // [R15]
    // One PI serves both loops so gains and limits are shared
    wire [15:0] pi_ref = power_loop ? power_ref : speed_ref; // [R19]
    wire [15:0] pi_fb = power_loop ? measured_power : speed_meas;
    wire signed [17:0] pi_err = 18'(pi_ref) - 18'(pi_fb);
    wire signed [35:0] p_term = 36'(signed'({1'b0, pi_proportional_gain}))
        * 36'(pi_err);
    wire signed [35:0] i_step = 36'(signed'({1'b0, pi_integral_gain}))
        * 36'(pi_err);
    wire signed [35:0] pi_sum = (p_term + integ_reg + i_step) >>> PI_SHIFT;
    wire sat_hi = pi_sum > 36'(signed'({1'b0, pi_upper_limit}));
    wire sat_lo = pi_sum < 36'(signed'({1'b0, pi_lower_limit}));
    wire [9:0] pi_clamped = sat_hi ? pi_upper_limit : sat_lo ?
        pi_lower_limit : pi_sum[9:0]; // [R13]
    wire [16:0] lim_level = 17'(power_ref) + 17'(power_hysteresis);
    wire over_limit = 17'(measured_power) > lim_level;
    wire use_pi = (loop_mode == LOOP_SPEED) || (power_loop &&
        (power_mode == PWR_CLOSED || (power_mode == PWR_LIMIT &&
        over_limit))); // [R12] [R17] [R18]
    wire [9:0] duty_next = use_pi ? pi_out_reg : ramp_reg;
    // Surge guard keeps braking gentle by reusing the rise rate
    wire [9:0] dec_step = surge_guard_enable ? accel_rate_limit :
        decel_rate_limit; // [R20]
    wire tick = tick_reg == 17'(CTRL_TICK - 1);

    // Command ramp, PI update and applied duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_reg <= 17'h0;
            ramp_reg <= 10'h0;
            integ_reg <= 36'sh0;
            pi_out_reg <= 10'h0;
            duty_reg <= 10'h0;
        end else begin
            tick_reg <= tick ? 17'h0 : tick_reg + 17'h1;
            if (tick) begin
                if (duty_cmd > ramp_reg) begin
                    ramp_reg <= (duty_cmd - ramp_reg > accel_rate_limit) ?
                        ramp_reg + accel_rate_limit : duty_cmd; // [R11]
                end else if (duty_cmd < ramp_reg) begin
                    ramp_reg <= (ramp_reg - duty_cmd > dec_step) ?
                        ramp_reg - dec_step : duty_cmd;
                end
                // Integrator held while clamped to avoid wind-up
                if (!sat_hi && !sat_lo) begin
                    integ_reg <= integ_reg + i_step; // [R13] [R19]
                end
                pi_out_reg <= pi_clamped;
            end
            duty_reg <= duty_next;
        end
    end

    // Checks next to the logic
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_cross;
        zc_event && zc_reg == ST_WAIT;
    endsequence
    sequence s_wait_done;
        zc_reg == ST_DELAY ##[1:1000] zc_reg == ST_WAIT;
    endsequence
    a_cross_starts: assert property (s_cross |=> zc_reg == ST_DELAY
        && cnt_reg == 20'h0) else $error("crossing not taken"); // [R01]
    a_float_idle: assert property (run && !in_ext && hs_switch |=>
        !hs_gate[$past(fl)] && !ls_gate[$past(fl)])
        else $error("floating phase driven"); // [R02]
    a_hs_lowon: assert property (run && eff_mod == MOD_HS |=>
        ls_gate[$past(lo_ph(state_reg))]) else $error("low side off");//[R03]
    a_ls_highon: assert property (run && eff_mod == MOD_LS |=>
        hs_gate[$past(hi_ph(state_reg))]) else $error("high side off");//[R04]
    a_mix_alt: assert property (run && eff_mod == MOD_MIX |=> // [R05]
        ($past(state_reg[0]) ? hs_gate[$past(hi_ph(state_reg))] :
        ls_gate[$past(lo_ph(state_reg))])) else $error("mix side off");
    a_var_mixed: assert property (run && var_mode && state_reg[0] |=> // [R07]
        hs_gate[$past(hi_ph(state_reg))]) else $error("var mode not mixed");
    a_clamp_120: assert property (!var_mode |-> lead_eff >=
        12'(LEAD_MIN_120)) else $error("lead below limit"); // [R09]
    a_clamp_var: assert property (var_mode |-> lead_eff >= 0 &&
        lead_eff <= 12'(LEAD_MAX_VAR)) else $error("var lead out"); // [R10]
    a_ramp_step: assert property (duty_cmd > ramp_reg |=>
        ramp_reg - $past(ramp_reg) <= $past(accel_rate_limit))
        else $error("ramp too steep"); // [R11]
    a_pi_bounds: assert property (tick ##1 pi_upper_limit >= pi_lower_limit
        |-> pi_out_reg <= pi_upper_limit) else $error("pi over limit");//[R13]
    a_limit_cmd: assert property (power_loop && power_mode == PWR_LIMIT &&
        !over_limit |=> duty_reg == $past(ramp_reg))
        else $error("limit mode not following command"); // [R18]
    a_state_step: assert property (commutate && !reverse_dir |=>
        state_reg == ((($past(state_reg)) == 3'h5) ? 3'h0 :
        $past(state_reg) + 3'h1)) else $error("bad state step"); // [R22]
endmodule // trap_drive
`default_nettype wire

// ### verilog/trap_drive_pkg.sv
// Constants, field layout and timing figures for the trapezoidal drive
package trap_drive_pkg;
    // Clock and derived timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned CTRL_PERIOD_US = 1000;
    localparam int unsigned CTRL_TICK_CYC = CTRL_PERIOD_US * CLK_PER_US;
    localparam int unsigned ZC_TIMEOUT_US = 100_000;
    localparam int unsigned ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_PER_US;
    localparam int unsigned VAR_FAST_US = 500;
    localparam int unsigned VAR_FAST_CYC = VAR_FAST_US * CLK_PER_US;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_MEAS = 8'h24;
    localparam int unsigned NCFG = 8;
    // Field positions
    localparam int COMM_LSB = 0;
    localparam int MOD_LSB = 2;
    localparam int LOOP_LSB = 4;
    localparam int PMODE_LSB = 6;
    localparam int SURGE_BIT = 8;
    localparam int EN_BIT = 9;
    localparam int REV_BIT = 10;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;
    localparam int SIGN_BIT = 8;
    // Reset values
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_LIMITS = 32'h0000_03FF;
    localparam logic [31:0] RST_FREQ = 32'h0014_0000;
    // Selector encodings
    localparam logic [1:0] COMM_120 = 2'h0;
    localparam logic [1:0] COMM_VAR = 2'h1;
    localparam logic [1:0] MOD_HS = 2'h0;
    localparam logic [1:0] MOD_LS = 2'h1;
    localparam logic [1:0] MOD_MIX = 2'h2;
    localparam logic [1:0] LOOP_SPEED = 2'h1;
    localparam logic [1:0] LOOP_POWER = 2'h2;
    localparam logic [1:0] PWR_CLOSED = 2'h1;
    localparam logic [1:0] PWR_LIMIT = 2'h2;
    // Angles in 0.04 degree units (one code step is three units)
    localparam int LEAD_SCALE = 3;
    localparam int LEAD_MIN_120 = -500;
    localparam int LEAD_MAX_VAR = 375;
    localparam int ANG_30 = 750;
    localparam int ANG_60 = 1500;
    // PWM frequency range in kHz and PI scaling
    localparam int FREQ_MIN_KHZ = 5;
    localparam int FREQ_MAX_KHZ = 100;
    localparam int PI_SHIFT = 12;
    localparam int DUTY_W = 10;
    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_DELAY = 1'b1
    } zc_state_t;
endpackage

// ### verif/drive_stage_model.sv
// Behavioural half-bridge stage and motor for the trapezoidal drive
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model #(
    parameter int IDLE = 600,
    parameter int DLY = 100
) (
    input wire logic aclk,
    input wire logic [2:0] hs_gate,
    input wire logic [2:0] ls_gate,
    input wire logic [15:0] power_level,
    output logic [2:0] bemf_cmp,
    output logic [15:0] measured_power
);
    int idle_cnt [3] = '{0, 0, 0};
    logic [2:0] cmp_q = 3'h5;
    logic none_on;
    assign none_on = ~|{hs_gate, ls_gate};
    // Floating means gates off past a PWM period; cross DLY cycles later
    always_ff @(posedge aclk) begin
        for (int p = 0; p < 3; p++) begin
            if (hs_gate[p] || ls_gate[p] || none_on) idle_cnt[p] <= 0;
            else if (idle_cnt[p] <= IDLE + DLY) idle_cnt[p] <= idle_cnt[p] + 1;
            if (idle_cnt[p] == IDLE + DLY) cmp_q[p] <= ~cmp_q[p];
        end
    end
    assign bemf_cmp = cmp_q;
    assign measured_power = power_level;
endmodule // drive_stage_model
`default_nettype wire

// ### verif/trap_drive_tb_top.sv
// Self-checking bench: registers, gate patterns and duty loops
`timescale 1ns/1ps
`default_nettype none
module trap_drive_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [15:0] power_level = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [2:0] bemf_cmp, hs_gate, ls_gate;
    logic [2:0] last = 3'h7;
    logic [15:0] measured_power;
    int miscompares = 0;
    int total_checks = 0;
    // Sourcing and sinking phase of each state, bit0 is phase A
    logic [2:0] hi_m [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic [2:0] lo_m [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    always #10 aclk = ~aclk;
    // Long counts shortened so the run stays brief
    trap_drive #(.CTRL_TICK(50), .ZC_TIMEOUT(2000), .VAR_FAST(500))
        trap_drive_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bemf_cmp,
        .measured_power, .hs_gate, .ls_gate);
    drive_stage_model drive_stage_model_i (.aclk, .hs_gate, .ls_gate,
        .power_level, .bemf_cmp, .measured_power);
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdt(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rdt(a);
        chk({rsp, rd}, {2'h0, e});
    endtask
    // Gates against the state table; sample only when state held still
    task automatic scan(input logic [1:0] m);
        logic [2:0] h, l, s;
        repeat (60) begin
            rdt(8'h20);
            s = rd[2:0];
            h = hs_gate;
            l = ls_gate;
            rdt(8'h20);
            if (s === rd[2:0] && s < 3'd6) begin
                if (m == 2'h1 || (m == 2'h2 && s[0]))
                    chk({h, l & ~lo_m[s]}, {hi_m[s], 3'h0});
                else chk({l, h & ~hi_m[s]}, {lo_m[s], 3'h0});
                if (last != 3'h7 && s != last)
                    chk(s, (last + 3'd1) % 3'd6);
                last = s;
            end
            repeat (40) @(posedge aclk);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well past the expected length of the tests
    initial begin
        repeat (60000) @(posedge aclk);
        miscompares++;
        results();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(8'h00, trap_drive_pkg::RST_CFG);
        rchk(8'h14, trap_drive_pkg::RST_LIMITS);
        rchk(8'h1C, trap_drive_pkg::RST_FREQ);
        wr(8'h08, 32'h0000_011E);
        rchk(8'h08, 32'h0000_011E);
        wr(8'h1C, 32'h0064_0000);
        rchk(8'h1C, 32'h0064_0000);
        wr(8'h20, 32'h0000_0007);
        chk(rsp, 2'h3);
        rdt(8'h28);
        chk({rsp, rd}, {2'h3, 32'h0});
        $display("test registers done");
        wr(8'h0C, 32'h0000_0002);
        wr(8'h00, 32'h0000_0200);
        wr(8'h04, 32'h0000_0064);
        rdt(8'h20);
        chk(rd[25:16] < 10'd100, 1'b1);
        repeat (3000) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16], 10'd100);
        // Decel rate is zero, so only the surge guard path can lower duty
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0300);
        repeat (1000) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16] < 10'd100, 1'b1);
        $display("test ramp done");
        wr(8'h0C, 32'h03FF_03FF);
        wr(8'h04, 32'h0000_03FF);
        for (int m = 0; m < 3; m++) begin
            wr(8'h00, 32'h0000_0200 | (m << 2));
            scan(m[1:0]);
            $display("test modulation %0d done", m);
        end
        // Partial duty so a wrongly switching high side shows up
        wr(8'h04, 32'h0000_0200);
        wr(8'h00, 32'h0000_0201);
        scan(2'h2);
        $display("test variable commutation done");
        wr(8'h14, 32'h0010_0080);
        wr(8'h10, 32'h0100_FFFF);
        wr(8'h18, 32'h0100_1000);
        wr(8'h00, 32'h0000_0210);
        repeat (2000) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16], 10'h010);
        rdt(8'h24);
        chk(rd[25:16], 10'h010);
        $display("test speed loop done");
        wr(8'h04, 32'h0000_0200);
        wr(8'h00, 32'h0000_02A0);
        repeat (2000) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16], 10'h200);
        power_level <= 16'hFFFF;
        wr(8'h00, 32'h0000_0260);
        repeat (2000) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16], 10'h010);
        // Power far above the limit hands the duty to the PI floor
        wr(8'h00, 32'h0000_02A0);
        repeat (200) @(posedge aclk);
        rdt(8'h20);
        chk(rd[25:16], 10'h010);
        $display("test power loop done");
        results();
    end
endmodule // trap_drive_tb_top
`default_nettype wire
